// File: hw/edrc_pkg.sv
// package: register map, field layout and timing constants of the rx counter and pointer block
package edrc_pkg;
    // register byte offsets
    localparam logic [15:0] ADDR_MISSED_FRAME_OVERFLOW_COUNTS = 16'h1020;
    localparam logic [15:0] ADDR_RX_FLAG_WATCHDOG_PERIOD = 16'h1024;
    localparam logic [15:0] ADDR_EVENT_STATUS = 16'h1028;
    localparam logic [15:0] ADDR_EVENT_CLEAR = 16'h102C;
    localparam logic [15:0] ADDR_EVENT_ENABLE = 16'h1030;
    localparam logic [15:0] ADDR_CURRENT_TX_DESCRIPTOR = 16'h1048;
    localparam logic [15:0] ADDR_CURRENT_RX_DESCRIPTOR = 16'h104C;
    localparam logic [15:0] ADDR_CURRENT_TX_BUFFER_ADDRESS = 16'h1050;
    localparam logic [15:0] ADDR_CURRENT_RX_BUFFER_ADDRESS = 16'h1054;

    // missed frame register layout
    localparam int DROP_CNT_W = 16;
    localparam int DROP_CNT_LSB = 0;
    localparam int DROP_WRAP_BIT = 16;
    localparam int APP_CNT_W = 11;
    localparam int APP_CNT_LSB = 17;
    localparam int FIFO_WRAP_BIT = 28;

    // watchdog period field and scaling
    localparam int WDT_PERIOD_W = 8;
    localparam int WDT_SHIFT = 8;
    localparam int WDT_UNIT = 256;
    localparam int WDT_CNT_W = WDT_PERIOD_W + WDT_SHIFT;

    // event status layout, shared by status, clear and enable
    localparam int EVT_W = 10;
    localparam int EVT_DROP_WRAP = 0;
    localparam int EVT_APP_WRAP = 1;
    localparam int EVT_FIFO_WRAP = 2;
    localparam int EVT_RX_WDT_TIMEOUT = 9;

    // reset values
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [EVT_W-1:0] RESET_EVT = 10'h000;
    localparam logic [WDT_PERIOD_W-1:0] RESET_WDT_PERIOD = 8'h00;

    // watchdog states
    typedef enum logic [0:0] {WDT_IDLE, WDT_RUN} edrc_wdt_state_t;
endpackage

// File: hw/edrc_wrap_cnt.sv
// wrapping event counter with read-to-clear and a sticky wrap flag
`timescale 1ns/1ns
module edrc_wrap_cnt #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk, // system clock
    input wire logic i_rstn, // async reset, active low
    input wire logic i_inc, // one-cycle count event
    input wire logic i_clr, // read-to-clear strobe
    output logic [WIDTH-1:0] o_count, // current count
    output logic o_wrap, // sticky wrap flag
    output logic o_wrap_evt // pulse when the count wraps
);
    logic at_max;

    assign at_max = &o_count;
    // a wrap in the clear cycle is not flagged: the read restarts the count and keeps that event as one
    assign o_wrap_evt = i_inc && at_max && !i_clr;

    // count; an event in the clear cycle is kept as the first new count
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_count <= '0;
        end else if (i_clr) begin
            o_count <= i_inc ? WIDTH'(1) : '0;
        end else if (i_inc) begin
            o_count <= o_count + WIDTH'(1);
        end
    end

    // wrap flag: set wins over clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wrap <= 1'b0;
        end else if (o_wrap_evt) begin
            o_wrap <= 1'b1;
        end else if (i_clr) begin
            o_wrap <= 1'b0;
        end
    end
endmodule

// File: hw/edrc_rx_mon.sv
// dma rx drop counters, rx completion watchdog and current pointer readback
//
// Notes on behaviour
// RULE1 - a 16-bit count in bits 15:0 grows by one per frame dropped for lack of a receive buffer and clears on read.
// RULE2 - bit 16 is set when that count wraps and clears on read.
// RULE3 - bits 27:17 hold a read-to-clear count of frames lost on the application side.
// RULE4 - bit 28 is set when the receive fifo overrun counter wraps and clears on read.
// RULE5 - the watchdog period is the 8-bit field in bits 7:0 times 256 clock cycles.
// RULE6 - the watchdog starts when a frame finishes with its completion report suppressed by its descriptor.
// RULE7 - on expiry the watchdog sets the receive-complete flag and stops.
// RULE8 - the watchdog is reset whenever the receive-complete flag becomes set.
// RULE9 - the current transmit descriptor address reads back as a 32-bit value that follows the dma.
// RULE10 - the current receive descriptor address reads back as a 32-bit value that follows the dma.
// RULE11 - the current transmit buffer address reads back as a 32-bit value that follows the dma.
// RULE12 - the current receive buffer address reads back as a 32-bit value that follows the dma.
// RULE13 - watchdog expiry is reported as status bit 9, which feeds the abnormal summary.
// RULE14 - a period field of zero disables the watchdog.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
module edrc_rx_mon
    import edrc_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic i_clk, // 100 MHz system clock
    input wire logic i_rstn, // async reset, active low
    input wire logic [ADDR_W-1:0] i_addr, // register byte address
    input wire logic [31:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [31:0] o_rdata, // read data, cycle after i_rd
    input wire logic i_drop_frame, // pulse: frame dropped, no rx buffer
    input wire logic i_app_lost_frame, // pulse: frame lost by application side
    input wire logic i_fifo_overrun_wrap, // pulse: rx fifo overrun counter wrapped
    input wire logic i_rx_frame_done, // pulse: rx dma finished a frame
    input wire logic i_rx_report_off, // descriptor word1 bit 31 of that frame
    input wire logic i_rx_complete_set, // pulse: frame sets the complete flag itself
    input wire logic i_rx_complete_clr, // pulse: complete flag cleared elsewhere
    input wire logic [31:0] i_cur_tx_desc_ptr, // dma current tx descriptor
    input wire logic [31:0] i_cur_rx_desc_ptr, // dma current rx descriptor
    input wire logic [31:0] i_cur_tx_buf_ptr, // dma current tx buffer
    input wire logic [31:0] i_cur_rx_buf_ptr, // dma current rx buffer
    output logic o_rx_complete_flag, // receive-complete flag
    output logic o_rx_wdt_timeout, // status bit 9, to abnormal summary
    output logic o_irq // level interrupt
);
    logic [DROP_CNT_W-1:0] dropped_frame_count;
    logic dropped_frame_count_wrap;
    logic drop_wrap_evt;
    logic [APP_CNT_W-1:0] app_lost_frame_count;
    logic app_wrap_evt;
    logic fifo_overrun_count_wrap;
    logic [WDT_PERIOD_W-1:0] rx_watchdog_period;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_enable;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    edrc_wdt_state_t wdt_state;
    logic [WDT_CNT_W-1:0] wdt_cnt;
    logic [WDT_CNT_W-1:0] wdt_limit;
    logic wdt_start;
    logic wdt_expire;
    logic complete_rise;
    logic cnt_rd;
    logic [31:0] next_rdata;

    // address decode, shared by read and write paths
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] reg_addr);
        hit = (a == ADDR_W'(reg_addr));
    endfunction

    assign cnt_rd = i_rd && hit(i_addr, ADDR_MISSED_FRAME_OVERFLOW_COUNTS);

    // dropped-frame counter with wrap flag
    edrc_wrap_cnt #(
        .WIDTH(DROP_CNT_W)
    ) u_drop_cnt (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_inc(i_drop_frame), // RULE1
        .i_clr(cnt_rd), // RULE1
        .o_count(dropped_frame_count),
        .o_wrap(dropped_frame_count_wrap), // RULE2
        .o_wrap_evt(drop_wrap_evt)
    );

    // application-side lost-frame counter; its wrap only raises an event
    edrc_wrap_cnt #(
        .WIDTH(APP_CNT_W)
    ) u_app_cnt (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_inc(i_app_lost_frame), // RULE3
        .i_clr(cnt_rd), // RULE3
        .o_count(app_lost_frame_count),
        .o_wrap(),
        .o_wrap_evt(app_wrap_evt)
    );

    // fifo overrun wrap flag: set wins over the read clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fifo_overrun_count_wrap <= 1'b0;
        end else if (i_fifo_overrun_wrap) begin
            fifo_overrun_count_wrap <= 1'b1; // RULE4
        end else if (cnt_rd) begin
            fifo_overrun_count_wrap <= 1'b0; // RULE4
        end
    end

    // watchdog period register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_watchdog_period <= RESET_WDT_PERIOD;
        end else if (i_wr && hit(i_addr, ADDR_RX_FLAG_WATCHDOG_PERIOD)) begin
            rx_watchdog_period <= i_wdata[WDT_PERIOD_W-1:0]; // RULE5
        end
    end

    // watchdog control terms; the limit follows the live field, so a rewrite takes effect mid-count
    assign wdt_limit = (WDT_CNT_W'(rx_watchdog_period) << WDT_SHIFT) - WDT_CNT_W'(1); // RULE5
    assign wdt_start = i_rx_frame_done && i_rx_report_off && (rx_watchdog_period != '0); // RULE6 RULE14
    assign wdt_expire = (wdt_state == WDT_RUN) && (wdt_cnt >= wdt_limit) && (rx_watchdog_period != '0); // RULE7
    assign complete_rise = i_rx_complete_set || wdt_expire;

    // watchdog state: any setting of the complete flag ends a run
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wdt_state <= WDT_IDLE;
        end else begin
            case (wdt_state)
                WDT_IDLE: begin
                    if (wdt_start && !i_rx_complete_set) begin
                        wdt_state <= WDT_RUN; // RULE6
                    end
                end
                WDT_RUN: begin
                    if (complete_rise) begin
                        wdt_state <= WDT_IDLE; // RULE7 RULE8
                    end else if (rx_watchdog_period == '0) begin
                        wdt_state <= WDT_IDLE; // RULE14
                    end
                end
                default: begin
                    wdt_state <= WDT_IDLE;
                end
            endcase
        end
    end

    // watchdog count; a fresh start restarts from zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wdt_cnt <= '0;
        end else if (complete_rise || wdt_state != WDT_RUN) begin
            wdt_cnt <= '0; // RULE8
        end else if (wdt_start) begin
            wdt_cnt <= '0; // RULE6
        end else begin
            wdt_cnt <= wdt_cnt + WDT_CNT_W'(1);
        end
    end

    // receive-complete flag: set wins over an outside clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx_complete_flag <= 1'b0;
        end else if (complete_rise) begin
            o_rx_complete_flag <= 1'b1; // RULE7
        end else if (i_rx_complete_clr) begin
            o_rx_complete_flag <= 1'b0;
        end
    end

    // event sources and clear strobes
    always_comb begin
        evt_set = '0;
        evt_set[EVT_DROP_WRAP] = drop_wrap_evt;
        evt_set[EVT_APP_WRAP] = app_wrap_evt;
        evt_set[EVT_FIFO_WRAP] = i_fifo_overrun_wrap;
        evt_set[EVT_RX_WDT_TIMEOUT] = wdt_expire; // RULE13
        evt_clr = (i_wr && hit(i_addr, ADDR_EVENT_CLEAR)) ? i_wdata[EVT_W-1:0] : '0;
    end

    // sticky status bits, write-one-to-clear through the clear register
    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi++) begin : g_evt
            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    evt_status[gi] <= 1'b0;
                end else if (evt_set[gi]) begin
                    evt_status[gi] <= 1'b1;
                end else if (evt_clr[gi]) begin
                    evt_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign o_rx_wdt_timeout = evt_status[EVT_RX_WDT_TIMEOUT]; // RULE13

    // interrupt enable register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            evt_enable <= RESET_EVT;
        end else if (i_wr && hit(i_addr, ADDR_EVENT_ENABLE)) begin
            evt_enable <= i_wdata[EVT_W-1:0];
        end
    end

    assign o_irq = |(evt_status & evt_enable);

    // read mux; pointers are sampled at the read so software sees the dma's live value
    always_comb begin
        next_rdata = RESET_WORD;
        if (hit(i_addr, ADDR_MISSED_FRAME_OVERFLOW_COUNTS)) begin
            next_rdata[DROP_CNT_LSB +: DROP_CNT_W] = dropped_frame_count; // RULE1
            next_rdata[DROP_WRAP_BIT] = dropped_frame_count_wrap; // RULE2
            next_rdata[APP_CNT_LSB +: APP_CNT_W] = app_lost_frame_count; // RULE3
            next_rdata[FIFO_WRAP_BIT] = fifo_overrun_count_wrap; // RULE4
        end else if (hit(i_addr, ADDR_RX_FLAG_WATCHDOG_PERIOD)) begin
            next_rdata[WDT_PERIOD_W-1:0] = rx_watchdog_period;
        end else if (hit(i_addr, ADDR_EVENT_STATUS)) begin
            next_rdata[EVT_W-1:0] = evt_status;
        end else if (hit(i_addr, ADDR_EVENT_ENABLE)) begin
            next_rdata[EVT_W-1:0] = evt_enable;
        end else if (hit(i_addr, ADDR_CURRENT_TX_DESCRIPTOR)) begin
            next_rdata = i_cur_tx_desc_ptr; // RULE9
        end else if (hit(i_addr, ADDR_CURRENT_RX_DESCRIPTOR)) begin
            next_rdata = i_cur_rx_desc_ptr; // RULE10
        end else if (hit(i_addr, ADDR_CURRENT_TX_BUFFER_ADDRESS)) begin
            next_rdata = i_cur_tx_buf_ptr; // RULE11
        end else if (hit(i_addr, ADDR_CURRENT_RX_BUFFER_ADDRESS)) begin
            next_rdata = i_cur_rx_buf_ptr; // RULE12
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= RESET_WORD;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= RESET_WORD;
        end
    end

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_wdt_arm;
        wdt_state == WDT_IDLE && wdt_start && !i_rx_complete_set;
    endsequence

    sequence s_wdt_last;
        wdt_state == WDT_RUN && wdt_cnt == wdt_limit && !i_rx_complete_set && rx_watchdog_period != '0;
    endsequence

    AST_DROP_INC: assert property (i_drop_frame && !cnt_rd && !(&dropped_frame_count)
        |=> dropped_frame_count == $past(dropped_frame_count) + DROP_CNT_W'(1)) // RULE1
        else $error("dropped frame count did not step");

    AST_DROP_RDCLR: assert property (cnt_rd && !i_drop_frame
        |=> dropped_frame_count == '0 && !dropped_frame_count_wrap) // RULE2
        else $error("dropped frame count not cleared by read");

    AST_DROP_WRAP: assert property (i_drop_frame && !cnt_rd && (&dropped_frame_count)
        |=> dropped_frame_count_wrap && dropped_frame_count == '0) // RULE2
        else $error("dropped frame wrap flag not set");

    AST_APP_INC: assert property (i_app_lost_frame && !cnt_rd && !(&app_lost_frame_count)
        |=> app_lost_frame_count == $past(app_lost_frame_count) + APP_CNT_W'(1)) // RULE3
        else $error("app lost frame count did not step");

    AST_FIFO_WRAP: assert property (i_fifo_overrun_wrap |=> fifo_overrun_count_wrap) // RULE4
        else $error("fifo overrun wrap flag lost");

    AST_WDT_START: assert property (s_wdt_arm |=> wdt_state == WDT_RUN && wdt_cnt == '0) // RULE6
        else $error("watchdog did not start");

    AST_WDT_EXPIRE: assert property (s_wdt_last
        |=> o_rx_complete_flag && wdt_state == WDT_IDLE && o_rx_wdt_timeout) // RULE7
        else $error("watchdog expiry did not set complete flag");

    AST_WDT_PERIOD: assert property (s_wdt_arm ##1 (wdt_state == WDT_RUN && !i_rx_complete_set
        && $stable(rx_watchdog_period) && !i_rx_frame_done) [*8]
        |-> wdt_cnt == WDT_CNT_W'(8) || wdt_state == WDT_IDLE) // RULE5
        else $error("watchdog count rate wrong");

    AST_WDT_RESET: assert property (i_rx_complete_set |=> wdt_state == WDT_IDLE && o_rx_complete_flag) // RULE8
        else $error("watchdog not reset by complete flag");

    AST_WDT_TMO_STS: assert property (wdt_expire |=> evt_status[EVT_RX_WDT_TIMEOUT]) // RULE13
        else $error("timeout status bit not set");

    AST_WDT_ZERO: assert property (rx_watchdog_period == '0 |=> !$rose(o_rx_wdt_timeout)) // RULE14
        else $error("timeout with zero period");

    AST_PTR_READ: assert property (i_rd && hit(i_addr, ADDR_CURRENT_RX_BUFFER_ADDRESS)
        |=> o_rdata == $past(i_cur_rx_buf_ptr)) // RULE12
        else $error("rx buffer pointer readback wrong");

    AST_TXD_READ: assert property (i_rd && hit(i_addr, ADDR_CURRENT_TX_DESCRIPTOR)
        |=> o_rdata == $past(i_cur_tx_desc_ptr)) // RULE9
        else $error("tx descriptor pointer readback wrong");

    AST_RXD_READ: assert property (i_rd && hit(i_addr, ADDR_CURRENT_RX_DESCRIPTOR)
        |=> o_rdata == $past(i_cur_rx_desc_ptr)) // RULE10
        else $error("rx descriptor pointer readback wrong");

    AST_TXB_READ: assert property (i_rd && hit(i_addr, ADDR_CURRENT_TX_BUFFER_ADDRESS)
        |=> o_rdata == $past(i_cur_tx_buf_ptr)) // RULE11
        else $error("tx buffer pointer readback wrong");

    AST_DROP_RDVAL: assert property (cnt_rd
        |=> o_rdata[DROP_CNT_LSB +: DROP_CNT_W] == $past(dropped_frame_count)) // RULE1
        else $error("dropped frame count readback wrong");

    AST_APP_RDCLR: assert property (cnt_rd && !i_app_lost_frame
        |=> app_lost_frame_count == '0) // RULE3
        else $error("app lost frame count not cleared by read");

    AST_FIFO_RDCLR: assert property (cnt_rd && !i_fifo_overrun_wrap
        |=> !fifo_overrun_count_wrap) // RULE4
        else $error("fifo overrun wrap flag not cleared by read");

    AST_PERIOD_WR: assert property (i_wr && hit(i_addr, ADDR_RX_FLAG_WATCHDOG_PERIOD)
        |=> rx_watchdog_period == $past(i_wdata[WDT_PERIOD_W-1:0])) // RULE5
        else $error("watchdog period write lost");

    AST_WDT_NOSTART: assert property (i_rx_frame_done && !i_rx_report_off && wdt_state == WDT_IDLE
        |=> wdt_state == WDT_IDLE) // RULE6
        else $error("watchdog started by a reporting frame");

    AST_TMO_CLEAR: assert property (evt_clr[EVT_RX_WDT_TIMEOUT] && !wdt_expire
        |=> !o_rx_wdt_timeout) // RULE13
        else $error("timeout status bit not cleared");

    AST_WDT_ZERO_STOP: assert property (rx_watchdog_period == '0
        |=> wdt_state == WDT_IDLE) // RULE14
        else $error("watchdog runs with zero period");
endmodule

// File: verification/edrc_dma_model.sv
// dma side model: frame events, descriptor completion and live pointers
`timescale 1ns/1ns
module edrc_dma_model (
    input wire logic i_clk, // system clock
    output logic [6:0] o_ev, // drop, app, fifo, done, report_off, cset, cclr
    output logic [31:0] o_ptr [4] // tx desc, rx desc, tx buf, rx buf
);
    initial begin
        o_ev = 7'h00;
        o_ptr = '{default: 32'h0000_0000};
    end

    // hold one event line high for n cycles, one event per cycle
    task automatic ev(input int idx, input int n);
        for (int k = 0; k <= n; k++) begin
            @(posedge i_clk) o_ev[idx] <= (k < n);
        end
    endtask

    // report_off only counts beside done; afterwards it shows the inverse so a stale level is never trusted
    task automatic frame(input logic off);
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk) begin
                o_ev[3] <= (k == 0);
                o_ev[4] <= (k == 0) ? off : ~off;
            end
        end
    endtask

    // pointers move as the dma walks its rings
    task automatic set_ptrs(input logic [31:0] base);
        @(posedge i_clk) begin
            for (int k = 0; k < 4; k++) begin
                o_ptr[k] <= base + 32'(k * 4);
            end
        end
    endtask
endmodule

// File: verification/tb_edrc_rx_mon.sv
// self-checking bench for the rx counters, rx watchdog and pointer readback
`timescale 1ns/1ns
module tb_edrc_rx_mon;
    import edrc_pkg::*;
    typedef struct {logic wr; logic [15:0] a; logic [31:0] d;} edrc_row_t;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [6:0] ev;
    logic [31:0] ptr [4];
    logic o_rx_complete_flag;
    logic o_rx_wdt_timeout;
    logic o_irq;
    int bad_count = 0;
    int n_checks = 0;
    // reads carry the expected value in d; writes carry the data
    edrc_row_t rows [14] = '{
        '{1'b0, 16'h1020, 32'h0000_0000}, '{1'b0, 16'h1024, 32'h0000_0000},
        '{1'b0, 16'h1028, 32'h0000_0000}, '{1'b0, 16'h1030, 32'h0000_0000},
        '{1'b1, 16'h1024, 32'hFFFF_FFFF}, '{1'b0, 16'h1024, 32'h0000_00FF},
        '{1'b1, 16'h1048, 32'h1234_5678}, '{1'b0, 16'h1048, 32'hA000_0000},
        '{1'b0, 16'h104C, 32'hA000_0004}, '{1'b0, 16'h1050, 32'hA000_0008},
        '{1'b0, 16'h1054, 32'hA000_000C}, '{1'b1, 16'h1028, 32'hFFFF_FFFF},
        '{1'b0, 16'h1028, 32'h0000_0000}, '{1'b0, 16'h1040, 32'h0000_0000}
    };

    edrc_dma_model dma (.i_clk(i_clk), .o_ev(ev), .o_ptr(ptr));

    edrc_rx_mon uut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_drop_frame(ev[0]), .i_app_lost_frame(ev[1]), .i_fifo_overrun_wrap(ev[2]),
        .i_rx_frame_done(ev[3]), .i_rx_report_off(ev[4]), .i_rx_complete_set(ev[5]),
        .i_rx_complete_clr(ev[6]), .i_cur_tx_desc_ptr(ptr[0]), .i_cur_rx_desc_ptr(ptr[1]),
        .i_cur_tx_buf_ptr(ptr[2]), .i_cur_rx_buf_ptr(ptr[3]), .o_rx_complete_flag(o_rx_complete_flag),
        .o_rx_wdt_timeout(o_rx_wdt_timeout), .o_irq(o_irq)
    );

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe, launched just after an edge
    task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_clk) begin
            i_wr <= 1'b1;
            i_addr <= a;
            i_wdata <= d;
        end
        @(posedge i_clk) i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rc(input logic [15:0] a, input logic [31:0] e);
        @(posedge i_clk) begin
            i_rd <= 1'b1;
            i_addr <= a;
        end
        @(posedge i_clk) i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // a watchdog run: the flag rises 'due' edges after the edge that samples the frame end
    task automatic wdt_run(input logic [31:0] due);
        dma.frame(1'b1);
        repeat (due - 1) @(posedge i_clk);
        #1 chk(32'(o_rx_complete_flag), 32'h0);
        @(posedge i_clk);
        #1 chk(32'(o_rx_complete_flag), 32'h1);
    endtask

    initial begin
        dma.set_ptrs(32'hA000_0000);
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        // reset values, access kinds, live pointers and an unmapped read
        foreach (rows[k]) begin
            if (rows[k].wr) bus_wr(rows[k].a, rows[k].d);
            else rc(rows[k].a, rows[k].d);
        end
        // back-to-back events on both counters and the fifo overrun wrap input, then read-to-clear
        fork
            dma.ev(0, 3);
            dma.ev(1, 5);
            dma.ev(2, 1);
        join
        rc(16'h1020, 32'h100A_0003);
        rc(16'h1020, 32'h0000_0000);
        rc(16'h1028, 32'h0000_0004);
        bus_wr(16'h102C, 32'h0000_0004);
        rc(16'h1028, 32'h0000_0000);
        // pointers follow the dma while it runs
        dma.set_ptrs(32'h5555_0000);
        rc(16'h1048, 32'h5555_0000);
        rc(16'h104C, 32'h5555_0004);
        rc(16'h1050, 32'h5555_0008);
        rc(16'h1054, 32'h5555_000C);
        // full wrap of both counters with the interrupt raised, masked and cleared
        bus_wr(16'h1030, 32'h0000_0003);
        fork
            dma.ev(0, 65536);
            dma.ev(1, 2048);
        join
        repeat (2) @(posedge i_clk);
        #1 chk(32'(o_irq), 32'h1);
        rc(16'h1028, 32'h0000_0003);
        rc(16'h1020, 32'h0001_0000);
        rc(16'h1020, 32'h0000_0000);
        bus_wr(16'h1030, 32'h0000_0000);
        #1 chk(32'(o_irq), 32'h0);
        bus_wr(16'h1030, 32'h0000_0203);
        bus_wr(16'h102C, 32'h0000_0003);
        #1 chk(32'(o_irq), 32'h0);
        // watchdog expiry with period one, reported as status bit 9
        bus_wr(16'h1024, 32'h0000_0001);
        wdt_run(32'(WDT_UNIT));
        chk(32'(o_rx_wdt_timeout), 32'h1);
        chk(32'(o_irq), 32'h1);
        rc(16'h1028, 32'h0000_0200);
        dma.ev(6, 1);
        bus_wr(16'h102C, 32'h0000_0200);
        #1 chk(32'(o_irq), 32'h0);
        // a second qualifying frame mid-run restarts the count
        dma.frame(1'b1);
        repeat (100) @(posedge i_clk);
        wdt_run(32'(WDT_UNIT));
        dma.ev(6, 1);
        bus_wr(16'h102C, 32'h0000_0200);
        // flag set by a frame itself resets the watchdog
        dma.frame(1'b1);
        repeat (50) @(posedge i_clk);
        dma.ev(5, 1);
        #1 chk(32'(o_rx_complete_flag), 32'h1);
        dma.ev(6, 1);
        repeat (300) @(posedge i_clk);
        #1 chk(32'({o_rx_complete_flag, o_rx_wdt_timeout}), 32'h0);
        // a frame that reports its own completion never starts the watchdog
        dma.frame(1'b0);
        repeat (300) @(posedge i_clk);
        #1 chk(32'({o_rx_complete_flag, o_rx_wdt_timeout}), 32'h0);
        // period zero stops a running watchdog and starts none
        dma.frame(1'b1);
        bus_wr(16'h1024, 32'h0000_0000);
        dma.frame(1'b1);
        repeat (400) @(posedge i_clk);
        #1 chk(32'({o_rx_complete_flag, o_rx_wdt_timeout}), 32'h0);
        // a watchdog left running would expire at once on a non-zero period
        bus_wr(16'h1024, 32'h0000_0001);
        repeat (2) @(posedge i_clk);
        #1 chk(32'(o_rx_complete_flag), 32'h0);
        // reset in mid-run clears counts and period
        dma.ev(0, 2);
        bus_wr(16'h1024, 32'h0000_0005);
        @(posedge i_clk) i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        rc(16'h1020, 32'h0000_0000);
        rc(16'h1024, 32'h0000_0000);
        report_and_stop();
    end

    // the tests need about 67,000 cycles; the limit leaves ample margin
    initial begin
        #1000000;
        bad_count++;
        report_and_stop();
    end
endmodule
